// ==== logic/sensmon_pkg.sv ====
// Package for the sensor monitor register group.
// Assumes an APB slave with byte offsets scaled to word addresses.
package sensmon_pkg;
   // ***************************************************************
   // Register indices and byte addresses
   // ***************************************************************
   localparam logic [7:0] IDX_BUFFER_FILL_STATUS    = 8'h01;
   localparam logic [7:0] IDX_ACCUMULATION_PROGRESS = 8'h02;
   localparam logic [7:0] IDX_CHAN0_SUM_LOW         = 8'h08;
   localparam logic [7:0] IDX_CHAN0_SUM_HIGH        = 8'h09;
   localparam logic [7:0] IDX_CHAN1_SUM_LOW         = 8'h0A;
   localparam logic [7:0] IDX_CHAN1_SUM_HIGH        = 8'h0B;
   localparam logic [7:0] IDX_OUTPUT_WORD_FORMAT    = 8'h28;
   localparam logic [7:0] IDX_SUMMING_ENABLE        = 8'h30;
   localparam logic [7:0] IDX_WINDOW_COMPARE_ENABLE = 8'h37;
   localparam logic [7:0] IDX_SEQUENCE_CONTROL      = 8'h10;
   localparam int         ADDR_LSB                  = 2;
   // ***************************************************************
   // Field codes and widths
   // ***************************************************************
   localparam logic [1:0] FMT_PLAIN_A   = 2'h0;
   localparam logic [1:0] FMT_CHAN_ID   = 2'h1;
   localparam logic [1:0] FMT_CHAN_VLD  = 2'h2;
   localparam logic [3:0] SUM_OFF_CODE  = 4'h0;
   localparam logic [3:0] SUM_ON_CODE   = 4'hF;
   localparam logic [2:0] CHAN_ID_ZERO  = 3'h0;
   localparam logic [2:0] CHAN_ID_ONE   = 3'h1;
   localparam logic [4:0] FILL_MAX      = 5'h10;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

   // Conversion sample entering the buffer
   typedef struct packed
   {
      logic [11:0] result;
      logic        chan;
      logic        valid;
   } sample_t;
endpackage

// ==== logic/word_formatter.sv ====
// Builds one 16-bit buffer word from a conversion sample.
// Assumes the format code is held stable by the register block.
`timescale 1ns/1ns
`default_nettype none
module word_formatter
   import sensmon_pkg::*;
(
   input  wire logic [1:0]  fmt,
   input  wire sample_t     smp,
   output logic      [15:0] word
);
   // ***************************************************************
   // Format mux
   // ***************************************************************
   // Channel identifier from the channel bit
   logic [2:0] chan_id;
   assign chan_id = smp.chan ? CHAN_ID_ONE : CHAN_ID_ZERO;

   // Codes 00 and 11 both pad with zeros
   always_comb
   begin
      if (fmt == FMT_CHAN_ID)
         word = {smp.result, chan_id, 1'b0};
      else if (fmt == FMT_CHAN_VLD)
         word = {smp.result, chan_id, smp.valid};
      else
         word = {smp.result, 4'h0};
   end
endmodule
`default_nettype wire

// ==== logic/sensmon_regs.sv ====
// Register group: buffer word format, fill status, accumulator, window
// comparator enable. Assumes APB master, datapath pulses synchronous.
//
// Functional notes
// - Formats 00/11: result then four zeros
// - Format 01: result, channel id, spare bit
// - Format 10: result, channel id, valid flag
// - Fill count field reports 0 to 16
// - Status and sums clear on resets, kick
// - Accumulator runs only at code 1111
// - Channel zero sum bytes at 08/09
// - Channel one sum bytes at 0A/0B
// - Sums-done count of finished accumulations
// - Window comparator on when bit set
// - Reserved bits always read zero
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sensmon_regs
   import sensmon_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        gcall_reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic      [31:0] prdata,
   output logic             pslverr,
   input  wire logic        sample_strobe,
   input  wire sample_t     sample_in,
   input  wire logic        sum_done,
   input  wire logic [15:0] chan0_sum_in,
   input  wire logic [15:0] chan1_sum_in,
   output logic             buf_write,
   output logic      [15:0] buf_word,
   output logic             summing_on,
   output logic             window_cmp_on,
   output logic             sequence_kick
);
   // ***************************************************************
   // Bus decode
   // ***************************************************************
   logic [7:0] idx;          // Word index of the access
   logic       wr_take;      // Write takes effect this edge
   logic       rd_take;      // Read data captured this edge
   logic       any_clear;    // Status clear condition
   logic [1:0] output_word_format;
   logic [3:0] summing_on_code;
   logic [4:0] filled_entry_count;
   logic [3:0] sums_done_count;
   logic [15:0] chan0_sum;
   logic [15:0] chan1_sum;
   logic [15:0] next_word;   // Formatted word for the buffer
   logic [31:0] next_rdata;  // Read mux result

   assign idx     = paddr[ADDR_LSB+7:ADDR_LSB];
   assign wr_take = psel & penable & pwrite & pready;
   assign rd_take = psel & penable & ~pwrite & pready;
   // Kick is a write of one to bit 0 of the control word
   assign any_clear = gcall_reset | (wr_take & pstrb[0] &
                      (idx == IDX_SEQUENCE_CONTROL) & pwdata[0]);

   // One wait state: ready in the access phase's second cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         pready <= 1'b0;
      else
         pready <= psel & penable & ~pready;
   end

   // Unmapped index answers with an error
   always_ff @(posedge clk)
   begin
      if (rst)
         pslverr <= 1'b0;
      else
         pslverr <= psel & penable & ~pready &
                    ~(idx == IDX_BUFFER_FILL_STATUS ||
                      idx == IDX_ACCUMULATION_PROGRESS ||
                      idx == IDX_CHAN0_SUM_LOW ||
                      idx == IDX_CHAN0_SUM_HIGH ||
                      idx == IDX_CHAN1_SUM_LOW ||
                      idx == IDX_CHAN1_SUM_HIGH ||
                      idx == IDX_OUTPUT_WORD_FORMAT ||
                      idx == IDX_SUMMING_ENABLE ||
                      idx == IDX_WINDOW_COMPARE_ENABLE ||
                      idx == IDX_SEQUENCE_CONTROL);
   end

   // ***************************************************************
   // Writable registers
   // ***************************************************************
   // Only low byte lane carries data; read-only indices fall through
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         output_word_format <= FMT_PLAIN_A;
         summing_on_code    <= SUM_OFF_CODE;
         window_cmp_on      <= 1'b0;
      end
      else if (wr_take && pstrb[0])
      begin
         if (idx == IDX_OUTPUT_WORD_FORMAT)
            output_word_format <= pwdata[1:0];
         else if (idx == IDX_SUMMING_ENABLE)
            summing_on_code <= pwdata[3:0];
         else if (idx == IDX_WINDOW_COMPARE_ENABLE)
            window_cmp_on <= pwdata[0];
      end
   end

   // Kick pulse to the sequencer, one cycle
   always_ff @(posedge clk)
   begin
      if (rst)
         sequence_kick <= 1'b0;
      else
         sequence_kick <= any_clear & ~gcall_reset;
   end

   // Reserved codes leave the accumulator off
   always_ff @(posedge clk)
   begin
      if (rst)
         summing_on <= 1'b0;
      else
         summing_on <= (summing_on_code == SUM_ON_CODE);
   end

   // ***************************************************************
   // Status registers
   // ***************************************************************
   // Fill count saturates at 16; clear wins since it restarts
   always_ff @(posedge clk)
   begin
      if (rst || any_clear)
         filled_entry_count <= 5'h00;
      else if (sample_strobe && filled_entry_count != FILL_MAX)
         filled_entry_count <= filled_entry_count + 5'h01;
   end

   // Sums and count follow the accumulator datapath while enabled
   always_ff @(posedge clk)
   begin
      if (rst || any_clear)
      begin
         sums_done_count <= 4'h0;
         chan0_sum       <= 16'h0000;
         chan1_sum       <= 16'h0000;
      end
      else if (sum_done && summing_on)
      begin
         sums_done_count <= sums_done_count + 4'h1;
         chan0_sum       <= chan0_sum_in;
         chan1_sum       <= chan1_sum_in;
      end
   end

   // ***************************************************************
   // Buffer word path
   // ***************************************************************
   word_formatter word_formatter_inst
   (
      .fmt  (output_word_format),
      .smp  (sample_in),
      .word (next_word)
   );

   // Registered so the buffer sees a clean word and strobe
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         buf_write <= 1'b0;
         buf_word  <= 16'h0000;
      end
      else
      begin
         buf_write <= sample_strobe;
         buf_word  <= next_word;
      end
   end

   // ***************************************************************
   // Read mux
   // ***************************************************************
   // Upper bits stay zero for every register
   always_comb
   begin
      next_rdata = WORD_ZERO;
      if (idx == IDX_BUFFER_FILL_STATUS)
         next_rdata[4:0] = filled_entry_count;
      else if (idx == IDX_ACCUMULATION_PROGRESS)
         next_rdata[3:0] = sums_done_count;
      else if (idx == IDX_CHAN0_SUM_LOW)
         next_rdata[7:0] = chan0_sum[7:0];
      else if (idx == IDX_CHAN0_SUM_HIGH)
         next_rdata[7:0] = chan0_sum[15:8];
      else if (idx == IDX_CHAN1_SUM_LOW)
         next_rdata[7:0] = chan1_sum[7:0];
      else if (idx == IDX_CHAN1_SUM_HIGH)
         next_rdata[7:0] = chan1_sum[15:8];
      else if (idx == IDX_OUTPUT_WORD_FORMAT)
         next_rdata[1:0] = output_word_format;
      else if (idx == IDX_SUMMING_ENABLE)
         next_rdata[3:0] = summing_on_code;
      else if (idx == IDX_WINDOW_COMPARE_ENABLE)
         next_rdata[0] = window_cmp_on;
   end

   // Read data latched with the ready edge
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata <= WORD_ZERO;
      else if (psel && penable && !pwrite && !pready)
         prdata <= next_rdata;
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_fill_cap;
      @(posedge clk) disable iff (rst) filled_entry_count <= FILL_MAX;
   endproperty
   a_fill_cap: assert property (p_fill_cap)
      else $error("fill count above sixteen");

   property p_clear;
      @(posedge clk) disable iff (rst)
      any_clear |=> (filled_entry_count == 5'h00 && chan0_sum == 16'h0000
                     && sums_done_count == 4'h0);
   endproperty
   a_clear: assert property (p_clear)
      else $error("status not cleared");

   property p_sum_on;
      @(posedge clk) disable iff (rst)
      ##1 summing_on == ($past(summing_on_code) == SUM_ON_CODE);
   endproperty
   a_sum_on: assert property (p_sum_on)
      else $error("accumulator enable mismatch");

   property p_fmt_pad;
      @(posedge clk) disable iff (rst)
      (output_word_format != FMT_CHAN_ID &&
       output_word_format != FMT_CHAN_VLD)
      |-> next_word[3:0] == 4'h0;
   endproperty
   a_fmt_pad: assert property (p_fmt_pad)
      else $error("pad bits not zero");

   property p_fmt_id;
      @(posedge clk) disable iff (rst)
      output_word_format == FMT_CHAN_ID
      |-> next_word[3:1] == {2'h0, sample_in.chan};
   endproperty
   a_fmt_id: assert property (p_fmt_id)
      else $error("channel id wrong");

   property p_fmt_vld;
      @(posedge clk) disable iff (rst)
      output_word_format == FMT_CHAN_VLD
      |-> next_word[0] == sample_in.valid;
   endproperty
   a_fmt_vld: assert property (p_fmt_vld)
      else $error("valid flag wrong");

   property p_count_step;
      @(posedge clk) disable iff (rst)
      (sum_done && summing_on && !any_clear)
      |=> sums_done_count == $past(sums_done_count) + 4'h1;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("sums count did not step");

   // Write to a read-only sum byte with no datapath load or clear
   sequence s_ro_write;
      psel && penable && pwrite && pready && idx == IDX_CHAN0_SUM_LOW
      && !sum_done && !any_clear;
   endsequence
   property p_ro_hold;
      @(posedge clk) disable iff (rst)
      s_ro_write |=> chan0_sum == $past(chan0_sum);
   endproperty
   a_ro_hold: assert property (p_ro_hold)
      else $error("read-only sum changed");

   property p_wcmp;
      @(posedge clk) disable iff (rst)
      (wr_take && pstrb[0] && idx == IDX_WINDOW_COMPARE_ENABLE)
      |=> window_cmp_on == $past(pwdata[0]);
   endproperty
   a_wcmp: assert property (p_wcmp)
      else $error("window enable not written");

   property p_rsvd;
      @(posedge clk) disable iff (rst)
      (rd_take && idx == IDX_SUMMING_ENABLE) |-> prdata[31:4] == 28'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits nonzero");
endmodule
`default_nettype wire

// ==== verif/apb_host_model.sv ====
// Host side model: an APB master that issues register transfers.
// Assumes one clock; the bench calls its transfer task.
`timescale 1ns/1ns
`default_nettype none
module apb_host_model
(
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb
);
   // ***************************************************************
   // Idle bus at time zero
   // ***************************************************************
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'hF;
   end

   // One transfer; request held until pready is seen at an edge
   task automatic xfer(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // No cycle count assumed; the bench watchdog ends a hang
      while (pready !== 1'b1)
         @(posedge clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines show their inverse, never the last value
      paddr   <= ~paddr;
      pwdata  <= ~pwdata;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb_sensmon_regs.sv ====
// Self-checking bench for the sensor monitor register group.
// Assumes the APB host model and the package constants.
`timescale 1ns/1ns
`default_nettype none
module tb_sensmon_regs
   import sensmon_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        gcall_reset = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        sample_strobe = 1'b0;
   sample_t     sample_in = '0;
   logic        sum_done = 1'b0;
   logic [15:0] chan0_sum_in = 16'h0000;
   logic [15:0] chan1_sum_in = 16'h0000;
   logic        buf_write, summing_on, window_cmp_on, sequence_kick;
   logic [15:0] buf_word;
   int          err_count = 0;
   int          checks_done = 0;
   int          kicks = 0;
   // Status registers first, then the writable ones
   logic [7:0]  regs [9] = '{IDX_BUFFER_FILL_STATUS,
      IDX_ACCUMULATION_PROGRESS, IDX_CHAN0_SUM_LOW, IDX_CHAN0_SUM_HIGH,
      IDX_CHAN1_SUM_LOW, IDX_CHAN1_SUM_HIGH, IDX_SUMMING_ENABLE,
      IDX_WINDOW_COMPARE_ENABLE, IDX_OUTPUT_WORD_FORMAT};

   // 125 MHz clock
   always #4 clk = ~clk;

   // Count kick pulses seen by the sequencer side
   always @(posedge clk)
      if (sequence_kick === 1'b1)
         kicks <= kicks + 1;

   sensmon_regs sensmon_regs_inst (.clk(clk), .rst(rst),
      .gcall_reset(gcall_reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sample_strobe(sample_strobe), .sample_in(sample_in),
      .sum_done(sum_done), .chan0_sum_in(chan0_sum_in),
      .chan1_sum_in(chan1_sum_in), .buf_write(buf_write),
      .buf_word(buf_word), .summing_on(summing_on),
      .window_cmp_on(window_cmp_on), .sequence_kick(sequence_kick));

   apb_host_model host_inst (.clk(clk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      host_inst.xfer(1'b1, idx, d, r, e);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      host_inst.xfer(1'b0, idx, WORD_ZERO, r, e);
      check(r, exp);
   endtask

   // Every status register back at zero
   task automatic zeros();
      for (int i = 0; i < 6; i++)
         rdc(regs[i], WORD_ZERO);
   endtask

   // One sample pulse; word is registered one cycle later
   task automatic push(input logic [11:0] res, input logic ch,
                       input logic v);
      @(posedge clk);
      sample_strobe <= 1'b1;
      sample_in     <= '{result: res, chan: ch, valid: v};
      @(posedge clk);
      sample_strobe <= 1'b0;
      #1;
   endtask

   // One finished accumulation with both channel sums
   task automatic sums(input logic [15:0] a, input logic [15:0] b);
      @(posedge clk);
      sum_done     <= 1'b1;
      chan0_sum_in <= a;
      chan1_sum_in <= b;
      @(posedge clk);
      sum_done     <= 1'b0;
      chan0_sum_in <= ~a;
      chan1_sum_in <= ~b;
   endtask

   task automatic complete_run();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Watchdog, far beyond the expected run
   initial
   begin
      #200000;
      err_count++;
      complete_run();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      logic [15:0] exp;
      logic [15:0] msk;
      logic [31:0] r;
      logic        e;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++)
         rdc(regs[i], WORD_ZERO);
      check({30'h0, summing_on, window_cmp_on}, 32'h0);
      // Reserved bits written high read back low
      wr(IDX_SUMMING_ENABLE, 32'h0000_00FF);
      wr(IDX_WINDOW_COMPARE_ENABLE, 32'h0000_00FF);
      rdc(IDX_SUMMING_ENABLE, 32'h0000_000F);
      rdc(IDX_WINDOW_COMPARE_ENABLE, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check({30'h0, summing_on, window_cmp_on}, 32'h3);
      // Every format code, both channels
      for (int f = 0; f < 4; f++)
      begin
         wr(IDX_OUTPUT_WORD_FORMAT, 32'(f));
         for (int c = 0; c < 2; c++)
         begin
            push(12'hA5C, c[0], ~c[0]);
            exp = (f == 1 || f == 2) ? {12'hA5C, 2'b00, c[0], ~c[0]}
                                     : {12'hA5C, 4'h0};
            msk = (f == 1) ? 16'hFFFE : 16'hFFFF;
            check({31'h0, buf_write}, 32'h1);
            check({16'h0, buf_word & msk}, {16'h0, exp & msk});
         end
      end
      wr(IDX_OUTPUT_WORD_FORMAT, 32'h0000_00FF);
      rdc(IDX_OUTPUT_WORD_FORMAT, 32'h0000_0003);
      rdc(IDX_BUFFER_FILL_STATUS, 32'h0000_0008);
      for (int i = 0; i < 9; i++)
         push(12'h123, 1'b0, 1'b1);
      wr(IDX_BUFFER_FILL_STATUS, 32'h0000_00FF);
      rdc(IDX_BUFFER_FILL_STATUS, 32'h0000_0010);
      // Sums land only while enabled
      sums(16'h1234, 16'hA55A);
      wr(IDX_CHAN0_SUM_LOW, 32'h0000_00FF);
      rdc(IDX_CHAN0_SUM_LOW, 32'h0000_0034);
      rdc(IDX_CHAN0_SUM_HIGH, 32'h0000_0012);
      rdc(IDX_CHAN1_SUM_LOW, 32'h0000_005A);
      rdc(IDX_CHAN1_SUM_HIGH, 32'h0000_00A5);
      rdc(IDX_ACCUMULATION_PROGRESS, 32'h0000_0001);
      wr(IDX_SUMMING_ENABLE, 32'h0000_0000);
      wr(IDX_WINDOW_COMPARE_ENABLE, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check({30'h0, summing_on, window_cmp_on}, 32'h0);
      sums(16'hFFFF, 16'hFFFF);
      rdc(IDX_CHAN0_SUM_LOW, 32'h0000_0034);
      rdc(IDX_ACCUMULATION_PROGRESS, 32'h0000_0001);
      // Sequence kick clears status and sums
      wr(IDX_SEQUENCE_CONTROL, 32'h0000_0001);
      zeros();
      rdc(IDX_SEQUENCE_CONTROL, WORD_ZERO);
      check(32'(kicks), 32'h1);
      // General call reset clears them as well
      wr(IDX_SUMMING_ENABLE, 32'h0000_000F);
      sums(16'h0F0F, 16'hF0F0);
      push(12'hFFF, 1'b1, 1'b1);
      rdc(IDX_CHAN1_SUM_HIGH, 32'h0000_00F0);
      @(posedge clk);
      gcall_reset <= 1'b1;
      @(posedge clk);
      gcall_reset <= 1'b0;
      zeros();
      check(32'(kicks), 32'h1);
      // Device reset in mid-run returns every register to zero
      wr(IDX_WINDOW_COMPARE_ENABLE, 32'h0000_0001);
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++)
         rdc(regs[i], WORD_ZERO);
      // Unmapped place answers with an error and zero data
      host_inst.xfer(1'b0, 8'h3F, WORD_ZERO, r, e);
      check({e, r[30:0]}, 32'h8000_0000);
      complete_run();
   end
endmodule
`default_nettype wire
